// ===== rtl/interval_timer.sv
// Interval timer host port: programming, latching, read-back, status
//
// Functional notes
// - Counters start unprogrammed; nothing counts before programming.
// - Control words are accepted only at port 3.
// - Count bytes go to the addressed counter, in its programmed byte format.
// - Access field 00 at control port is a latch command, not programming.
// - Latch freezes count until read or reprogrammed, then follows again.
// - Latch leaves mode and counting untouched; each counter latches independently.
// - A second latch before reading is ignored.
// - Two-byte read order is tracked per counter; interleaving other counters is fine.
// - Read and write byte order are tracked separately per counter.
// - Read-back applies to every counter whose select bit D3..D1 is one.
// - Read-back with D5 low latches counts of selected counters.
// - Repeated count read-back before read is ignored.
// - Read-back with D4 low latches status, read through counter port.
// - Status is output level, pending-load flag, then six mode bits.
// - Pending-load flag is one until new count moves into counter.
// - Control word sets pending-load flag only for addressed counter.
// - Count write sets pending-load flag, after high byte in word format.
// - Four ports: three counters and one control port.
// - Latched status reads first, then latched count bytes, then live count.
// - Writes need chip select; port-3 reads and idle cycles float the bus.
// - A second status latch before reading is ignored.
// - Programming clears both count holding bytes.
`timescale 1ns/1ns
module interval_timer
    import timer_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic port_select_low_in,
    input wire logic port_select_high_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n_out,
    input wire logic [2:0] ctr_clk_in,
    input wire logic [2:0] ctr_gate_in,
    output logic [2:0] ctr_out_out
);

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_sync_r;
    logic wr_n_q_r;
    logic rd_n_q_r;
    logic [2:0] clk_q_r;

    wire [PIN_W-1:0] pin_vec = {cs_n_in, rd_n_in, wr_n_in, port_select_high_in,
        port_select_low_in, data_in, ctr_clk_in, ctr_gate_in};

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_meta_r <= {PIN_W{1'b1}};
            pin_sync_r <= {PIN_W{1'b1}};
        end else begin
            pin_meta_r <= pin_vec;
            pin_sync_r <= pin_meta_r;
        end
    end

    wire cs_n_s = pin_sync_r[18];
    wire rd_n_s = pin_sync_r[17];
    wire wr_n_s = pin_sync_r[16];
    wire [1:0] port_s = pin_sync_r[15:14];
    wire [7:0] data_s = pin_sync_r[13:6];
    wire [2:0] clk_s = pin_sync_r[5:3];
    wire [2:0] gate_s = pin_sync_r[2:0];

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_n_q_r <= 1'b1;
            rd_n_q_r <= 1'b1;
            clk_q_r <= 3'h7; // Matches synchroniser reset, no false edge
        end else begin
            wr_n_q_r <= wr_n_s;
            rd_n_q_r <= rd_n_s;
            clk_q_r <= clk_s;
        end
    end

    // ------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------
    wire wr_rise = wr_n_s && !wr_n_q_r;
    wire rd_rise = rd_n_s && !rd_n_q_r;
    wire bus_write = wr_rise && !cs_n_s;
    wire is_ctrl = port_s == PORT_CTRL;
    wire ctrl_wr = bus_write && is_ctrl;
    wire ctr_wr = bus_write && !is_ctrl;
    wire rd_done = rd_rise && !cs_n_s && !is_ctrl;
    wire rd_active = !cs_n_s && !rd_n_s && wr_n_s && !is_ctrl;
    wire [1:0] cmd_sel = data_s[SEL_POS +: 2];
    wire [1:0] cmd_fmt = data_s[FMT_POS +: 2];
    wire [1:0] rd_port = is_ctrl ? 2'h0 : port_s;

    // ------------------------------------------------------------
    // Per-counter read bytes and element links
    // ------------------------------------------------------------
    logic [7:0] rd_byte [CTR_COUNT];

    ctr_if cif [CTR_COUNT] ();

    // ------------------------------------------------------------
    // Per-counter programming and read state
    // ------------------------------------------------------------
    for (genvar i = 0; i < CTR_COUNT; i++) begin : g_ctr
        logic [5:0] mode_r;
        logic prog_r;
        logic [7:0] load_lo_r;
        logic [7:0] load_hi_r;
        logic wr_hi_r;
        logic rd_hi_r;
        logic [15:0] hold_r;
        logic hold_on_r;
        logic hold_on_nxt;
        logic [7:0] st_r;
        logic st_held_r;
        logic st_held_nxt;
        logic null_r;
        logic null_nxt;

        // ------------------------------------------------------------
        // Command decode
        // ------------------------------------------------------------
        wire [1:0] fmt = mode_r[FMT_POS +: 2];
        wire fmt_word = fmt == FMT_WORD;
        wire sel_me = cmd_sel == 2'(i);
        wire prog_hit = ctrl_wr && sel_me && cmd_fmt != FMT_LATCH;
        wire latch_hit = ctrl_wr && sel_me && cmd_fmt == FMT_LATCH;
        wire rb_hit = ctrl_wr && cmd_sel == SEL_READBACK && data_s[RB_SEL_BASE + i];
        wire rb_cnt = rb_hit && !data_s[RB_COUNT_N_BIT];
        wire rb_st = rb_hit && !data_s[RB_STATUS_N_BIT];
        wire cnt_wr = ctr_wr && port_s == 2'(i) && prog_r;
        wire cnt_rd = rd_done && port_s == 2'(i);
        wire cnt_rd_byte = cnt_rd && !st_held_r;
        wire wr_to_lo = fmt == FMT_LSB || (fmt_word && !wr_hi_r);
        wire wr_to_hi = fmt == FMT_MSB || (fmt_word && wr_hi_r);
        wire wr_last = !fmt_word || wr_hi_r;
        wire rd_last = !fmt_word || rd_hi_r;
        wire count_done = cnt_wr && wr_last;
        wire cnt_latch = latch_hit || rb_cnt;
        wire [15:0] cnt_view = hold_on_r ? hold_r : cif[i].ce;
        wire rd_hi_sel = fmt == FMT_MSB || (fmt_word && rd_hi_r);
        wire [7:0] status = {cif[i].out_lvl, null_r, mode_r};

        // ------------------------------------------------------------
        // Mode and programmed flag
        // ------------------------------------------------------------
        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                mode_r <= MODE_RST;
                prog_r <= 1'b0;
            end else if (prog_hit) begin
                mode_r <= data_s[MODE_W-1:0];
                prog_r <= 1'b1;
            end
        end

        // ------------------------------------------------------------
        // Count holding bytes
        // ------------------------------------------------------------
        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                load_lo_r <= BYTE_RST;
            end else if (prog_hit) begin
                load_lo_r <= BYTE_RST;
            end else if (cnt_wr && wr_to_lo) begin
                load_lo_r <= data_s;
            end
        end

        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                load_hi_r <= BYTE_RST;
            end else if (prog_hit) begin
                load_hi_r <= BYTE_RST;
            end else if (cnt_wr && wr_to_hi) begin
                load_hi_r <= data_s;
            end
        end

        // ------------------------------------------------------------
        // Separate write and read byte order
        // ------------------------------------------------------------
        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                wr_hi_r <= 1'b0;
            end else if (prog_hit) begin
                wr_hi_r <= 1'b0;
            end else if (cnt_wr && fmt_word) begin
                wr_hi_r <= !wr_hi_r;
            end
        end

        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                rd_hi_r <= 1'b0;
            end else if (prog_hit) begin
                rd_hi_r <= 1'b0;
            end else if (cnt_rd_byte && fmt_word) begin
                rd_hi_r <= !rd_hi_r;
            end
        end

        // ------------------------------------------------------------
        // Count hold latch
        // ------------------------------------------------------------
        always_comb begin
            hold_on_nxt = hold_on_r;
            if (cnt_rd_byte && rd_last) begin
                hold_on_nxt = 1'b0;
            end
            if (cnt_latch) begin
                hold_on_nxt = 1'b1;
            end
            if (prog_hit) begin
                hold_on_nxt = 1'b0;
            end
        end

        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                hold_on_r <= 1'b0;
            end else begin
                hold_on_r <= hold_on_nxt;
            end
        end

        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                hold_r <= COUNT_RST;
            end else if (cnt_latch && !hold_on_r) begin
                hold_r <= cif[i].ce;
            end
        end

        // ------------------------------------------------------------
        // Latched status byte
        // ------------------------------------------------------------
        always_comb begin
            st_held_nxt = st_held_r;
            if (cnt_rd) begin
                st_held_nxt = 1'b0;
            end
            if (rb_st) begin
                st_held_nxt = 1'b1;
            end
            if (prog_hit) begin
                st_held_nxt = 1'b0;
            end
        end

        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                st_held_r <= 1'b0;
            end else begin
                st_held_r <= st_held_nxt;
            end
        end

        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                st_r <= BYTE_RST;
            end else if (rb_st && !st_held_r) begin
                st_r <= status;
            end
        end

        // ------------------------------------------------------------
        // Pending-load flag, set wins over clear
        // ------------------------------------------------------------
        always_comb begin
            null_nxt = null_r;
            if (cif[i].loaded) begin
                null_nxt = 1'b0;
            end
            if (prog_hit) begin
                null_nxt = 1'b1;
            end
            if (count_done) begin
                null_nxt = 1'b1;
            end
        end

        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                null_r <= 1'b0;
            end else begin
                null_r <= null_nxt;
            end
        end

        // ------------------------------------------------------------
        // Byte presented on a read of this counter
        // ------------------------------------------------------------
        wire [7:0] cnt_byte = rd_hi_sel ? cnt_view[15:8] : cnt_view[7:0];
        assign rd_byte[i] = st_held_r ? st_r : cnt_byte;

        // ------------------------------------------------------------
        // Counting element link
        // ------------------------------------------------------------
        assign cif[i].prog = prog_hit;
        assign cif[i].load = count_done;
        assign cif[i].load_val = {load_hi_r, load_lo_r};
        assign cif[i].gate = gate_s[i];
        assign cif[i].clk_rise = clk_s[i] && !clk_q_r[i];
        assign ctr_out_out[i] = cif[i].out_lvl;

        counting_unit u_unit (
            .clk_sys_in(clk_sys_in),
            .sys_rst_in(sys_rst_in),
            .bus(cif[i].unit)
        );
    end

    // ------------------------------------------------------------
    // Data bus driver
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            data_out <= BYTE_RST;
        end else if (rd_active) begin
            data_out <= rd_byte[rd_port];
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            data_oe_n_out <= 1'b1;
        end else begin
            data_oe_n_out <= !rd_active;
        end
    end

endmodule

// ===== rtl/timer_pkg.sv
// Shared constants for the interval timer host port
package timer_pkg;

    // ------------------------------------------------------------
    // Port map
    // ------------------------------------------------------------
    localparam int CTR_COUNT = 3;
    localparam int CTR_WIDTH = 16;
    localparam logic [1:0] PORT_CTRL = 2'h3;

    // ------------------------------------------------------------
    // Command byte fields
    // ------------------------------------------------------------
    localparam int SEL_POS = 6;
    localparam int FMT_POS = 4;
    localparam int MODE_W = 6;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] FMT_LATCH = 2'h0;
    localparam logic [1:0] FMT_LSB = 2'h1;
    localparam logic [1:0] FMT_MSB = 2'h2;
    localparam logic [1:0] FMT_WORD = 2'h3;
    localparam int RB_COUNT_N_BIT = 5;
    localparam int RB_STATUS_N_BIT = 4;
    localparam int RB_SEL_BASE = 1;

    // ------------------------------------------------------------
    // Status byte fields
    // ------------------------------------------------------------
    localparam int STAT_OUT_BIT = 7;
    localparam int STAT_NULL_BIT = 6;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [5:0] MODE_RST = 6'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam int SYNC_STAGES = 2;
    localparam int PIN_W = 19;

endpackage

// ===== rtl/ctr_if.sv
// Link between the host port logic and one counting element
`timescale 1ns/1ns
interface ctr_if;
    logic prog;
    logic load;
    logic [15:0] load_val;
    logic gate;
    logic clk_rise;
    logic [15:0] ce;
    logic out_lvl;
    logic loaded;

    modport ctl (output prog, load, load_val, gate, clk_rise, input ce, out_lvl, loaded);
    modport unit (input prog, load, load_val, gate, clk_rise, output ce, out_lvl, loaded);
endinterface

// ===== rtl/counting_unit.sv
// One counting element with pending-load transfer
`timescale 1ns/1ns
module counting_unit
    import timer_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    ctr_if.unit bus
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] ce_r;
    logic pend_r;
    logic armed_r;
    logic out_r;
    logic loaded_r;

    wire xfer = bus.clk_rise && pend_r;
    wire step = bus.clk_rise && !pend_r && armed_r && bus.gate;
    wire at_one = ce_r == COUNT_ONE;

    assign bus.ce = ce_r;
    assign bus.out_lvl = out_r;
    assign bus.loaded = loaded_r;

    // ------------------------------------------------------------
    // Counting element, stepped on synchronised counter clock
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ce_r <= COUNT_RST;
        end else if (xfer) begin
            ce_r <= bus.load_val;
        end else if (step) begin
            ce_r <= 16'(ce_r - COUNT_ONE);
        end
    end

    // Pending transfer, new load request wins over transfer
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pend_r <= 1'b0;
        end else if (bus.load) begin
            pend_r <= 1'b1;
        end else if (bus.prog || xfer) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            armed_r <= 1'b0;
        end else if (bus.prog) begin
            armed_r <= 1'b0;
        end else if (xfer) begin
            armed_r <= 1'b1;
        end
    end

    // Output level: low after programming, high at terminal count
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            out_r <= 1'b0;
        end else if (bus.prog) begin
            out_r <= 1'b0;
        end else if (step && at_one) begin
            out_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            loaded_r <= 1'b0;
        end else begin
            loaded_r <= xfer && !bus.load;
        end
    end

endmodule

// ===== dv/interval_timer_assertions.sv
// Concurrent checks on the interval timer host pins
`timescale 1ns/1ns
module interval_timer_assertions (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic port_select_low_in,
    input wire logic port_select_high_in,
    input wire logic [2:0] ctr_clk_in,
    input wire logic [2:0] ctr_gate_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n_out,
    input wire logic [2:0] ctr_out_out
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wire logic ctl_port = port_select_low_in && port_select_high_in;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_read_held;
        !rd_n_in && !cs_n_in && !ctl_port && wr_n_in;
    endsequence
    sequence s_pins_quiet;
        $stable(ctr_clk_in) && wr_n_in;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_reset_quiet;
        $fell(sys_rst_in) |-> data_oe_n_out && (ctr_out_out == 3'h0);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");

    property p_no_select;
        cs_n_in [*4] |-> data_oe_n_out;
    endproperty
    a_no_select: assert property (p_no_select) else $error("bus driven without select");

    property p_ctl_read;
        (!cs_n_in && ctl_port) [*4] |-> data_oe_n_out;
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("bus driven at control port");

    property p_no_read;
        rd_n_in [*4] |-> data_oe_n_out;
    endproperty
    a_no_read: assert property (p_no_read) else $error("bus driven without read");

    property p_read_drive;
        s_read_held [*5] |-> !data_oe_n_out;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("counter read not driven");

    property p_data_hold;
        rd_n_in [*6] |-> $stable(data_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("read data moved while idle");

    property p_clk_idle;
        s_pins_quiet [*5] |=> $stable(ctr_out_out);
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("output moved without clock");

    property p_gate_idle;
        (ctr_gate_in == 3'h0 && wr_n_in) [*5] |=> $stable(ctr_out_out);
    endproperty
    a_gate_idle: assert property (p_gate_idle) else $error("output moved with gates low");
endmodule

// ===== dv/host_bus_model.sv
// Host processor model driving the timer parallel bus pins
`timescale 1ns/1ns
module host_bus_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] dev_data_in,
    input wire logic dev_oe_n_in,
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic port_low_out,
    output logic port_high_out,
    output logic [7:0] bus_out
);
    logic drive_r;
    logic [7:0] wdata_r;
    logic [7:0] last_r = 8'h00;

    // Released bus shows a changing pattern
    assign bus_out = drive_r ? wdata_r : (!dev_oe_n_in ? dev_data_in : ~last_r);

    always @(posedge clk_sys_in) begin
        last_r <= bus_out;
    end

    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        port_low_out = 1'b0;
        port_high_out = 1'b0;
        drive_r = 1'b0;
        wdata_r = 8'h00;
    end

    // Whole write, select and data held past the strobe rise
    task automatic wr(input logic [1:0] p, input logic [7:0] v);
        @(posedge clk_sys_in);
        cs_n_out <= 1'b0;
        {port_high_out, port_low_out} <= p;
        wdata_r <= v;
        drive_r <= 1'b1;
        wr_n_out <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        wr_n_out <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        cs_n_out <= 1'b1;
        drive_r <= 1'b0;
    endtask

    // One caller finishes a read before the next begins
    task automatic rd(input logic [1:0] p, output logic [7:0] v, output logic oe_n);
        @(posedge clk_sys_in);
        cs_n_out <= 1'b0;
        {port_high_out, port_low_out} <= p;
        rd_n_out <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        v = bus_out;
        oe_n = dev_oe_n_in;
        rd_n_out <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        cs_n_out <= 1'b1;
    endtask
endmodule

// ===== dv/interval_timer_tb_top.sv
// Self-checking bench for the interval timer host port
`timescale 1ns/1ns
module interval_timer_tb_top;
    logic clk_sys_in;
    logic sys_rst_in;
    logic [2:0] ctr_clk;
    logic [2:0] ctr_gate;
    logic cs_n, rd_n, wr_n, psl, psh, oe_n, rd_oe;
    logic [7:0] bus, data_out, rd_val, b1, b2;
    logic [2:0] ctr_out;
    logic [15:0] n0, n1, v16;
    int mismatches, num_checks, cycles;

    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    host_bus_model host_bus_model_i (.clk_sys_in(clk_sys_in), .dev_data_in(data_out),
        .dev_oe_n_in(oe_n), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
        .port_low_out(psl), .port_high_out(psh), .bus_out(bus));

    interval_timer interval_timer_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .port_select_low_in(psl),
        .port_select_high_in(psh), .data_in(bus), .data_out(data_out), .data_oe_n_out(oe_n),
        .ctr_clk_in(ctr_clk), .ctr_gate_in(ctr_gate), .ctr_out_out(ctr_out));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] stat_exp(input logic o, input logic nl, input logic [7:0] w);
        return {o, nl, w[5:0]};
    endfunction

    task automatic rd(input logic [1:0] p, input logic [7:0] exp, input string what);
        host_bus_model_i.rd(p, rd_val, rd_oe);
        chk(what, exp, rd_val);
    endtask

    task automatic rd16(input logic [1:0] p, input logic [15:0] exp, input string what);
        rd(p, exp[7:0], what);
        rd(p, exp[15:8], what);
    endtask

    task automatic wr(input logic [1:0] p, input logic [7:0] v);
        host_bus_model_i.wr(p, v);
    endtask

    task automatic pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            ctr_clk <= m;
            repeat (3) @(posedge clk_sys_in);
            ctr_clk <= 3'h0;
            repeat (3) @(posedge clk_sys_in);
        end
    endtask

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys_in) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst_in = 1'b1;
        ctr_clk = 3'h0;
        ctr_gate = 3'h0;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        void'($urandom(32'h5125));
        n0 = 16'($urandom_range(16'hFF00, 16'h0100));
        n1 = 16'($urandom_range(16'hFF00, 16'h0100));
        b1 = 8'($urandom_range(8'hFF, 8'h10));
        b2 = 8'($urandom_range(8'hFF, 8'h01));
        repeat (5) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        wr(2'h3, 8'h34);
        wr(2'h3, 8'hE2);
        rd(2'h0, 8'h74, "status after programming");
        done("status");
        wr(2'h0, n0[7:0]);
        wr(2'h0, n0[15:8]);
        wr(2'h3, 8'hE2);
        rd(2'h0, 8'h74, "null before load");
        pulse(3'h1, 1);
        wr(2'h3, 8'hE2);
        rd(2'h0, 8'h34, "null after load");
        done("load");
        wr(2'h3, 8'h00);
        ctr_gate <= 3'h1;
        pulse(3'h1, 3);
        rd16(2'h0, n0, "latched count");
        rd16(2'h0, n0 - 16'h0003, "live count");
        wr(2'h3, 8'h00);
        pulse(3'h1, 2);
        wr(2'h3, 8'h00);
        pulse(3'h1, 2);
        rd16(2'h0, n0 - 16'h0003, "first latch kept");
        rd16(2'h0, n0 - 16'h0007, "count after latch");
        done("latch");
        v16 = n0 - 16'h0007;
        wr(2'h3, 8'h50);
        wr(2'h1, b1);
        wr(2'h3, 8'hA0);
        wr(2'h2, b2);
        ctr_gate <= 3'h0;
        pulse(3'h7, 1);
        wr(2'h3, 8'hCE);
        ctr_gate <= 3'h7;
        pulse(3'h7, 2);
        wr(2'h3, 8'hCE);
        rd(2'h0, 8'h34, "ctr0 status first");
        rd(2'h0, v16[7:0], "ctr0 latched low");
        rd(2'h1, 8'h10, "ctr1 status");
        rd(2'h1, b1, "ctr1 latched");
        rd(2'h0, v16[15:8], "ctr0 latched high");
        rd(2'h2, 8'h20, "ctr2 status");
        rd(2'h2, b2, "ctr2 latched");
        rd(2'h1, b1 - 8'h02, "ctr1 live");
        rd(2'h2, b2 - 8'h01, "ctr2 live");
        done("read-back");
        v16 = n0 - 16'h0009;
        ctr_gate <= 3'h0;
        rd(2'h0, v16[7:0], "live low");
        wr(2'h0, n1[7:0]);
        rd(2'h0, v16[15:8], "live high");
        wr(2'h0, n1[15:8]);
        pulse(3'h1, 1);
        rd16(2'h0, n1, "reloaded count");
        done("interleave");
        host_bus_model_i.rd(2'h3, rd_val, rd_oe);
        chk("control port drive", 8'h01, {7'h00, rd_oe});
        done("control read");
        wr(2'h3, 8'h50);
        wr(2'h1, 8'h02);
        ctr_gate <= 3'h2;
        pulse(3'h2, 3);
        chk("counter outputs", 8'h02, {5'h00, ctr_out});
        wr(2'h3, 8'hE4);
        rd(2'h1, stat_exp(1'b1, 1'b0, 8'h50), "ctr1 terminal status");
        done("terminal");
        report_and_stop();
    end
endmodule

bind interval_timer interval_timer_assertions interval_timer_assertions_i (
    .clk_sys_in, .sys_rst_in, .cs_n_in, .rd_n_in, .wr_n_in, .port_select_low_in,
    .port_select_high_in, .ctr_clk_in, .ctr_gate_in, .data_out, .data_oe_n_out, .ctr_out_out);
